/* File: tcmp_pkg.sv */
// Package with spans, widths and encodings for the tightly coupled memory port
package tcmp_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int IDX_W = 10;
    // Instruction span: 4 KB at a build-time base
    localparam logic [31:0] ITCM_BASE = 32'h0001_0000;
    localparam int ITCM_SPAN_BITS = 12;
    // Data span: 4 KB at a build-time base
    localparam logic [31:0] DTCM_BASE = 32'h0002_0000;
    localparam int DTCM_SPAN_BITS = 12;
    // Fixed read latency of the memory slave in cycles
    localparam int READ_LAT = 1;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [3:0] ZERO_BE = 4'h0;
    // Cache operation codes on the data request
    typedef enum logic [1:0] {
        TCMP_OP_NONE,
        TCMP_OP_FLUSH,
        TCMP_OP_INVAL
    } tcmp_cop_type;
endpackage

/* File: tcmp_span_if.sv */
// Interface carrying one span decoder's address and match result
`timescale 1ns/10ps
interface tcmp_span_if;
    logic [31:0] addr;
    logic hit;
    modport dec (input addr, output hit);
    modport user (output addr, input hit);
endinterface

/* File: tcmp_span_dec.sv */
// Span decoder comparing the address bits above the span size with a base
`timescale 1ns/10ps
module tcmp_span_dec
    import tcmp_pkg::*;
#(
    parameter logic [31:0] BASE = 32'h0000_0000,
    parameter int SPAN_BITS = 12
)
(
    tcmp_span_if.dec span
);
    // Only the upper bits take part, so the span is size aligned
    assign span.hit = (span.addr[31:SPAN_BITS] == BASE[31:SPAN_BITS]);
endmodule

/* File: tcmp_core_port.sv */
// Function
// RULE_01: Each tightly coupled port links exactly one master to one slave.
// RULE_02: Tightly coupled data path is fixed at 32 bits both ways.
// RULE_03: No dynamic bus sizing; accesses are never split or merged.
// RULE_04: Slave returns read data one cycle later, writes at once, no waits.
// RULE_05: Core decodes every instruction and data address against the spans.
// RULE_06: Addresses inside a span go to the matching tightly coupled port.
// RULE_07: Span accesses bypass the instruction and data caches entirely.
// RULE_08: Cache management operations never affect tightly coupled memory.
// RULE_09: The slave must be writable on-chip RAM, never ROM.
// RULE_10: Each tightly coupled master uses one unshared memory slave port.
// RULE_11: A memory attaches to only one tightly coupled master.
// RULE_12: Instruction port gives fixed latency reads; data port reads and writes.
// RULE_13: Tightly coupled ports are separate from regular master ports.
// RULE_14: Spans sit in ordinary address space, reached by normal loads and fetches.
// RULE_15: Access time is constant with no arbitration delay.
// RULE_16: The slave is exactly one port of an on-chip synchronous memory.
// RULE_17: Instruction tightly coupled master only reads, never writes.
// RULE_18: Span match compares only bits above the build-time span size.
// RULE_19: Data write presents address, data, enables in one cycle, no stall.
`timescale 1ns/10ps
module tcmp_core_port
    import tcmp_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Core instruction fetch request
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    output logic fetch_valid,
    output logic [31:0] fetch_data,
    // Core data request
    input wire logic data_req,
    input wire logic data_wr,
    input wire logic [31:0] data_addr,
    input wire logic [31:0] data_wdata,
    input wire logic [3:0] data_be,
    input wire tcmp_cop_type data_cop,
    output logic data_valid,
    output logic [31:0] data_rdata,
    // Regular instruction master toward the cache path
    output logic imst_read,
    output logic [31:0] imst_addr,
    input wire logic imst_valid,
    input wire logic [31:0] imst_rdata,
    // Regular data master toward the cache path
    output logic dmst_read,
    output logic dmst_write,
    output logic [31:0] dmst_addr,
    output logic [31:0] dmst_wdata,
    output logic [3:0] dmst_be,
    output tcmp_cop_type dmst_cop,
    input wire logic dmst_valid,
    input wire logic [31:0] dmst_rdata,
    // Tightly coupled instruction port to one RAM port
    output logic itcm_read,
    output logic [IDX_W-1:0] itcm_addr,
    input wire logic [31:0] itcm_rdata,
    // Tightly coupled data port to one RAM port
    output logic dtcm_read,
    output logic dtcm_write,
    output logic [IDX_W-1:0] dtcm_addr,
    output logic [31:0] dtcm_wdata,
    output logic [3:0] dtcm_be,
    input wire logic [31:0] dtcm_rdata
);
    tcmp_span_if ispan ();
    tcmp_span_if dspan ();

    // RULE_14: plain byte addresses
    // RULE_05: decode fetch address
    assign ispan.addr = fetch_addr;
    // RULE_05: decode data address
    assign dspan.addr = data_addr;

    // RULE_18: instruction span match
    tcmp_span_dec #(.BASE(ITCM_BASE), .SPAN_BITS(ITCM_SPAN_BITS)) u_idec (.span(ispan));
    // RULE_18: data span match
    tcmp_span_dec #(.BASE(DTCM_BASE), .SPAN_BITS(DTCM_SPAN_BITS)) u_ddec (.span(dspan));

    logic next_itcm_read;
    logic [IDX_W-1:0] next_itcm_addr;
    logic next_dtcm_read;
    logic next_dtcm_write;
    logic [IDX_W-1:0] next_dtcm_addr;
    logic [31:0] next_dtcm_wdata;
    logic [3:0] next_dtcm_be;
    logic next_imst_read;
    logic [31:0] next_imst_addr;
    logic next_dmst_read;
    logic next_dmst_write;
    logic [31:0] next_dmst_addr;
    logic [31:0] next_dmst_wdata;
    logic [3:0] next_dmst_be;
    tcmp_cop_type next_dmst_cop;
    // Read-pending flags for the cycle when the RAM returns data
    logic ipend;
    logic dpend;
    logic next_ipend;
    logic next_dpend;
    logic next_fetch_valid;
    logic [31:0] next_fetch_data;
    logic next_data_valid;
    logic [31:0] next_data_rdata;
    logic is_cop;

    // Steering of requests onto the tightly coupled or regular ports
    always_comb
    begin
        is_cop = (data_cop != TCMP_OP_NONE);
        // RULE_06: in-span fetch goes to instruction port
        // RULE_17: instruction port never writes
        next_itcm_read = fetch_req && ispan.hit;
        next_itcm_addr = fetch_addr[ITCM_SPAN_BITS-1:2];
        // RULE_13: separate regular master
        // RULE_07: cache master only sees out-of-span fetches
        next_imst_read = fetch_req && !ispan.hit;
        next_imst_addr = fetch_addr;
        // RULE_06: in-span load or store to data port
        // RULE_08: cache operations never reach the RAM
        // RULE_19: one-cycle write, full word and enables
        next_dtcm_read = data_req && dspan.hit && !data_wr && !is_cop;
        next_dtcm_write = data_req && dspan.hit && data_wr && !is_cop;
        next_dtcm_addr = data_addr[DTCM_SPAN_BITS-1:2];
        // RULE_02: full 32-bit word
        // RULE_03: word and enables passed unchanged
        next_dtcm_wdata = data_wdata;
        next_dtcm_be = data_be;
        // RULE_07: cache path only for out-of-span accesses
        // RULE_08: in-span cache operations are dropped
        next_dmst_read = data_req && !dspan.hit && !data_wr && !is_cop;
        next_dmst_write = data_req && !dspan.hit && data_wr && !is_cop;
        next_dmst_addr = data_addr;
        next_dmst_wdata = data_wdata;
        next_dmst_be = data_be;
        next_dmst_cop = (data_req && !dspan.hit) ? data_cop : TCMP_OP_NONE;
        next_ipend = itcm_read;
        next_dpend = dtcm_read;
        // RULE_04: RAM data one cycle after the strobe, no waits
        // RULE_15: fixed latency, no arbitration on this path
        if (ipend)
        begin
            next_fetch_valid = 1'b1;
            next_fetch_data = itcm_rdata;
        end
        else
        begin
            next_fetch_valid = imst_valid;
            next_fetch_data = imst_valid ? imst_rdata : ZERO_WORD;
        end
        // RULE_12: fixed latency data reads
        if (dpend)
        begin
            next_data_valid = 1'b1;
            next_data_rdata = dtcm_rdata;
        end
        else
        begin
            next_data_valid = dmst_valid;
            next_data_rdata = dmst_valid ? dmst_rdata : ZERO_WORD;
        end
    end

    // Registers for all ports; outputs come straight from flip-flops
    // RULE_01: one master, one slave
    // RULE_10: unshared slave port
    // RULE_11: one memory per master
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            itcm_read <= 1'b0;
            itcm_addr <= '0;
            dtcm_read <= 1'b0;
            dtcm_write <= 1'b0;
            dtcm_addr <= '0;
            dtcm_wdata <= ZERO_WORD;
            dtcm_be <= ZERO_BE;
            imst_read <= 1'b0;
            imst_addr <= ZERO_WORD;
            dmst_read <= 1'b0;
            dmst_write <= 1'b0;
            dmst_addr <= ZERO_WORD;
            dmst_wdata <= ZERO_WORD;
            dmst_be <= ZERO_BE;
            dmst_cop <= TCMP_OP_NONE;
            ipend <= 1'b0;
            dpend <= 1'b0;
            fetch_valid <= 1'b0;
            fetch_data <= ZERO_WORD;
            data_valid <= 1'b0;
            data_rdata <= ZERO_WORD;
        end
        else
        begin
            itcm_read <= next_itcm_read;
            itcm_addr <= next_itcm_addr;
            dtcm_read <= next_dtcm_read;
            dtcm_write <= next_dtcm_write;
            dtcm_addr <= next_dtcm_addr;
            dtcm_wdata <= next_dtcm_wdata;
            dtcm_be <= next_dtcm_be;
            imst_read <= next_imst_read;
            imst_addr <= next_imst_addr;
            dmst_read <= next_dmst_read;
            dmst_write <= next_dmst_write;
            dmst_addr <= next_dmst_addr;
            dmst_wdata <= next_dmst_wdata;
            dmst_be <= next_dmst_be;
            dmst_cop <= next_dmst_cop;
            ipend <= next_ipend;
            dpend <= next_dpend;
            fetch_valid <= next_fetch_valid;
            fetch_data <= next_fetch_data;
            data_valid <= next_data_valid;
            data_rdata <= next_data_rdata;
        end
    end

    // Checks on steering and latency
    a_ifetch_steer: assert property (@(posedge core_clk) disable iff (srst)
        fetch_req && ispan.hit |=> itcm_read && !imst_read) // RULE_06
        else $error("in-span fetch not on instruction port");
    a_cache_bypass: assert property (@(posedge core_clk) disable iff (srst)
        data_req && dspan.hit |=> !dmst_read && !dmst_write) // RULE_07
        else $error("in-span data access reached cache master");
    a_cop_ignored: assert property (@(posedge core_clk) disable iff (srst)
        data_req && dspan.hit && data_cop != TCMP_OP_NONE
        |=> !dtcm_read && !dtcm_write && dmst_cop == TCMP_OP_NONE) // RULE_08
        else $error("cache operation touched tightly coupled memory");
    a_ilat_fixed: assert property (@(posedge core_clk) disable iff (srst)
        itcm_read |-> ##2 fetch_valid && fetch_data == $past(itcm_rdata)) // RULE_15
        else $error("instruction port latency not fixed");
    a_dlat_fixed: assert property (@(posedge core_clk) disable iff (srst)
        dtcm_read |-> ##2 data_valid && data_rdata == $past(dtcm_rdata)) // RULE_12
        else $error("data port latency not fixed");
    a_wr_one_cycle: assert property (@(posedge core_clk) disable iff (srst)
        data_req && data_wr && dspan.hit && data_cop == TCMP_OP_NONE
        |=> dtcm_write && dtcm_wdata == $past(data_wdata)
            && dtcm_be == $past(data_be)) // RULE_19
        else $error("data write not presented whole");
    a_wr_no_read: assert property (@(posedge core_clk) disable iff (srst)
        !(dtcm_read && dtcm_write)) // RULE_03
        else $error("read and write at once on data port");
    a_span_match: assert property (@(posedge core_clk) disable iff (srst)
        fetch_req && fetch_addr[31:ITCM_SPAN_BITS] != ITCM_BASE[31:ITCM_SPAN_BITS]
        |=> !itcm_read && imst_read) // RULE_18
        else $error("out-of-span fetch on instruction port");
    a_addr_decode: assert property (@(posedge core_clk) disable iff (srst)
        data_req && !data_wr && data_cop == TCMP_OP_NONE
        |=> dtcm_read != dmst_read) // RULE_05
        else $error("data load not steered to exactly one port");
endmodule

/* File: tcmp_ram_model.sv */
// Behavioural single-port synchronous RAM on one tightly coupled port
`timescale 1ns/10ps
module tcmp_ram_model
    import tcmp_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Request from the tightly coupled master
    input wire logic read,
    input wire logic write,
    input wire logic [IDX_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [3:0] be,
    // Read return
    output logic [31:0] rdata
);
    logic [31:0] mem [0:1023];
    logic [31:0] last = 32'h0000_0000;
    logic rd_d = 1'b0;
    // Known pattern so the bench can predict every word
    initial
    begin
        for (int k = 0; k < 1024; k++)
            mem[k] = 32'hA500_0000 ^ k;
    end
    always @(posedge core_clk)
    begin
        rd_d <= read;
        if (read)
            last <= mem[addr];
        if (write)
            for (int b = 0; b < 4; b++)
                if (be[b])
                    mem[addr][8*b +: 8] <= wdata[8*b +: 8];
    end
    // Data lines carry junk outside the return cycle, so a late sample is caught
    assign rdata = rd_d ? last : ~last;
endmodule

/* File: tb_top.sv */
// Self-checking bench for the tightly coupled memory port
`timescale 1ns/10ps
module tb_top;
    import tcmp_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic fetch_req, fetch_valid, data_req, data_wr, data_valid, imst_read, imst_valid;
    logic dmst_read, dmst_write, dmst_valid, itcm_read, dtcm_read, dtcm_write;
    logic [31:0] fetch_addr, fetch_data, data_addr, data_wdata, data_rdata, imst_addr;
    logic [31:0] imst_rdata, dmst_addr, dmst_wdata, dmst_rdata, itcm_rdata, dtcm_wdata;
    logic [31:0] dtcm_rdata, r, ia, da;
    logic [3:0] data_be, dmst_be, dtcm_be;
    logic [IDX_W-1:0] itcm_addr, dtcm_addr;
    tcmp_cop_type data_cop, dmst_cop;
    logic fh, dh, ld, st, ir, dr;
    logic [31:0] dmem [0:1023];
    logic [31:0] fq[$], dq[$];
    int ft[$], dt[$];
    int n_errors = 0;
    int num_checks = 0;
    tcmp_core_port uut (.core_clk(core_clk), .srst(srst),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
        .fetch_data(fetch_data), .data_req(data_req), .data_wr(data_wr),
        .data_addr(data_addr), .data_wdata(data_wdata), .data_be(data_be),
        .data_cop(data_cop), .data_valid(data_valid), .data_rdata(data_rdata),
        .imst_read(imst_read), .imst_addr(imst_addr), .imst_valid(imst_valid),
        .imst_rdata(imst_rdata), .dmst_read(dmst_read), .dmst_write(dmst_write),
        .dmst_addr(dmst_addr), .dmst_wdata(dmst_wdata), .dmst_be(dmst_be),
        .dmst_cop(dmst_cop), .dmst_valid(dmst_valid), .dmst_rdata(dmst_rdata),
        .itcm_read(itcm_read), .itcm_addr(itcm_addr), .itcm_rdata(itcm_rdata),
        .dtcm_read(dtcm_read), .dtcm_write(dtcm_write), .dtcm_addr(dtcm_addr),
        .dtcm_wdata(dtcm_wdata), .dtcm_be(dtcm_be), .dtcm_rdata(dtcm_rdata));
    tcmp_ram_model iram (.core_clk(core_clk), .read(itcm_read), .write(1'b0),
        .addr(itcm_addr), .wdata(ZERO_WORD), .be(ZERO_BE), .rdata(itcm_rdata));
    tcmp_ram_model dram (.core_clk(core_clk), .read(dtcm_read), .write(dtcm_write),
        .addr(dtcm_addr), .wdata(dtcm_wdata), .be(dtcm_be), .rdata(dtcm_rdata));
    // 100 MHz clock
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // A quarter near a span base, a quarter anywhere inside it, a quarter anywhere in the 4 KB past its end, a quarter anywhere
    function automatic logic [31:0] pick(input logic [31:0] base);
        logic [31:0] x;
        x = $urandom;
        case (x[1:0])
            2'h0: return base + {x[11:2], 2'h0};
            2'h1: return base + {x[5:2], 2'h0};
            2'h2: return base + 32'h0000_1000 + {x[11:2], 2'h0};
            default: return {x[31:2], 2'h0};
        endcase
    endfunction
    // Regular masters answer a cycle after the strobe, matching the RAM so order holds
    always @(posedge core_clk)
    begin
        ir = imst_read;
        ia = imst_addr;
        dr = dmst_read;
        da = dmst_addr;
        #1;
        imst_valid = ir;
        imst_rdata = ir ? ~ia : $urandom;
        dmst_valid = dr;
        dmst_rdata = dr ? da ^ 32'h5A5A_5A5A : $urandom;
    end
    // Random mixed traffic for the first 3000 cycles, then 4 idle cycles, checked against the bench model
    initial
    begin
        r = $urandom(32'hAC80_65A4);
        {fetch_req, data_req, data_wr, ld, st} = 5'h00;
        {fetch_addr, data_addr, data_wdata} = {3{ZERO_WORD}};
        data_be = ZERO_BE;
        data_cop = TCMP_OP_NONE;
        fh = 1'b0;
        dh = 1'b0;
        for (int k = 0; k < 1024; k++)
            dmem[k] = 32'hA500_0000 ^ k;
        repeat (20) @(posedge core_clk);
        #1;
        chk({fetch_valid, data_valid, itcm_read, dtcm_read, dtcm_write, imst_read}, 0);
        srst = 1'b0;
        for (int c = 0; c < 3004; c++)
        begin
            @(posedge core_clk);
            #1;
            chk({itcm_read, imst_read}, {fetch_req & fh, fetch_req & ~fh});
            if (fetch_req)
                chk(fh ? itcm_addr : imst_addr, fh ? fetch_addr[11:2] : fetch_addr);
            chk({dtcm_read, dtcm_write, dmst_read, dmst_write}, {dh & ld, dh & st, ~dh & ld, ~dh & st});
            if (data_req)
                chk(dmst_cop, dh ? TCMP_OP_NONE : data_cop);
            if (ld | st)
                chk(dh ? dtcm_addr : dmst_addr, dh ? data_addr[11:2] : data_addr);
            if (st)
                chk(dh ? dtcm_be : dmst_be, data_be);
            if (st)
                chk(dh ? dtcm_wdata : dmst_wdata, data_wdata);
            chk(fetch_valid, ft.size() > 0 && ft[0] == c);
            if (ft.size() > 0 && ft[0] == c)
            begin
                chk(fetch_data, fq.pop_front());
                ft.pop_front();
            end
            chk(data_valid, dt.size() > 0 && dt[0] == c);
            if (dt.size() > 0 && dt[0] == c)
            begin
                chk(data_rdata, dq.pop_front());
                dt.pop_front();
            end
            r = (c < 3000) ? $urandom : ZERO_WORD;
            fetch_req = r[0];
            fetch_addr = pick(ITCM_BASE);
            fh = (fetch_addr >> ITCM_SPAN_BITS) == (ITCM_BASE >> ITCM_SPAN_BITS);
            data_req = r[1] | r[2];
            data_cop = (r[6:4] == 3'h7) ? TCMP_OP_FLUSH : (r[6:4] == 3'h6) ? TCMP_OP_INVAL : TCMP_OP_NONE;
            data_wr = r[3] & (data_cop == TCMP_OP_NONE);
            data_addr = pick(DTCM_BASE);
            dh = (data_addr >> DTCM_SPAN_BITS) == (DTCM_BASE >> DTCM_SPAN_BITS);
            data_wdata = $urandom;
            data_be = r[10:7];
            ld = data_req & (data_cop == TCMP_OP_NONE) & ~data_wr;
            st = data_req & data_wr;
            if (fetch_req)
            begin
                fq.push_back(fh ? 32'hA500_0000 ^ fetch_addr[11:2] : ~fetch_addr);
                ft.push_back(c + 3);
            end
            if (ld)
            begin
                dq.push_back(dh ? dmem[data_addr[11:2]] : data_addr ^ 32'h5A5A_5A5A);
                dt.push_back(c + 3);
            end
            for (int b = 0; b < 4; b++)
                if (st & dh & data_be[b])
                    dmem[data_addr[11:2]][8*b +: 8] = data_wdata[8*b +: 8];
        end
        chk(ft.size() + dt.size(), 0);
        end_of_test();
    end
endmodule
